/* uoc_pkg.sv */
// Shared constants and types of the unified on-chip cache.
package uoc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int LINE_WORDS = 4;
	localparam int WORD_SEL_W = 2;
	localparam int OFFSET_W = 4;
	localparam int LINES_SMALL = 512;
	localparam int LINES_LARGE = 1024;
	localparam int WBUF_DEPTH = 4;
	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [1:0] FIRST_BEAT = 2'h0;
	localparam logic [OFFSET_W-1:0] LINE_BASE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		UOC_IDLE = 2'b00,
		UOC_EVICT = 2'b01,
		UOC_FILL = 2'b11,
		UOC_DRAIN = 2'b10
	} uoc_state_e;
endpackage

/* uoc_wbuf_if.sv */
// Interface between the cache controller and its write buffer.
`timescale 1ns/100ps
interface uoc_wbuf_if;
	import uoc_pkg::*;
	logic push;
	logic [ADDR_W-1:0] pushAddr;
	logic [DATA_W-1:0] pushData;
	logic pop;
	logic full;
	logic empty;
	logic [ADDR_W-1:0] headAddr;
	logic [DATA_W-1:0] headData;
	modport store (input push, input pushAddr, input pushData, input pop,
		output full, output empty, output headAddr, output headData);
	modport ctrl (output push, output pushAddr, output pushData, output pop,
		input full, input empty, input headAddr, input headData);
endinterface

/* uoc_write_buffer.sv */
// Posted write buffer that lets writes finish before their bus cycles.
`timescale 1ns/100ps
module uoc_write_buffer #(
	parameter int DEPTH = uoc_pkg::WBUF_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	uoc_wbuf_if.store wb
);
	import uoc_pkg::*;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	logic [ADDR_W-1:0] addrQ [DEPTH];
	logic [DATA_W-1:0] dataQ [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [PTR_W:0] count_q;
	logic doPush;
	logic doPop;

	assign doPush = wb.push && (count_q != CNT_FULL);
	assign doPop = wb.pop && (count_q != '0);
	assign wb.full = (count_q == CNT_FULL);
	assign wb.empty = (count_q == '0);
	assign wb.headAddr = addrQ[rdPtr_q];
	assign wb.headData = dataQ[rdPtr_q];

	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			addrQ[wrPtr_q] <= wb.pushAddr;
			dataQ[wrPtr_q] <= wb.pushData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doPush) begin
				wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + 1'b1;
			end
			if (doPush && !doPop) begin
				count_q <= count_q + 1'b1;
			end else if (doPop && !doPush) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	chk_no_overflow: assert property (@(posedge sys_clk) disable iff (rst)
		wb.full && !wb.pop |=> wb.full)
		else $error("write buffer lost an entry while full");
endmodule

/* uoc_cache.sv */
// Unified instruction and data cache with line fills, write buffer and snooping.
`timescale 1ns/100ps
module uoc_cache #(
	parameter bit LARGE = 1'b0,
	parameter int WBUF_DEPTH = uoc_pkg::WBUF_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cpuReq,
	input wire logic cpuWe,
	input wire logic cpuWbLine,
	input wire logic [uoc_pkg::ADDR_W-1:0] cpuAddr,
	input wire logic [uoc_pkg::DATA_W-1:0] cpuWdata,
	output logic cpuDone,
	output logic [uoc_pkg::DATA_W-1:0] cpuRdata,
	output logic memReq,
	output logic memWe,
	output logic memBurst,
	output logic [uoc_pkg::ADDR_W-1:0] memAddr,
	output logic [uoc_pkg::DATA_W-1:0] memWdata,
	input wire logic memAck,
	input wire logic [uoc_pkg::DATA_W-1:0] memRdata,
	input wire logic snoopValid,
	input wire logic [uoc_pkg::ADDR_W-1:0] snoopAddr,
	input wire logic flush
);
	import uoc_pkg::*;
	localparam int LINES = LARGE ? LINES_LARGE : LINES_SMALL;
	localparam int IDX_W = $clog2(LINES);
	localparam int TAG_W = ADDR_W - OFFSET_W - IDX_W;

	uoc_state_e state_q;
	logic [DATA_W-1:0] dataQ [LINES*LINE_WORDS];
	logic [TAG_W-1:0] tagQ [LINES];
	logic [LINES-1:0] valid_q;
	logic [LINES-1:0] dirty_q;
	logic [LINES-1:0] wbMode_q;
	logic [1:0] beat_q;
	logic [IDX_W-1:0] fillIdx_q;
	logic [TAG_W-1:0] fillTag_q;
	logic fillWb_q;
	logic kill_q;
	logic cpuDone_q;
	logic [DATA_W-1:0] cpuRdata_q;
	logic memReq_q;
	logic memWe_q;
	logic memBurst_q;
	logic [ADDR_W-1:0] memAddr_q;
	logic [DATA_W-1:0] memWdata_q;
	logic [IDX_W-1:0] idx;
	logic [TAG_W-1:0] tag;
	logic [WORD_SEL_W-1:0] word;
	logic [IDX_W-1:0] sIdx;
	logic [TAG_W-1:0] sTag;
	logic hit;
	logic accept;
	logic rdHit;
	logic wrStore;
	logic wrPush;
	logic rdMiss;
	logic drainGo;
	logic fillBeat;
	logic fillEnd;
	logic killNow;
	logic snoopHit;

	uoc_wbuf_if wb ();

	uoc_write_buffer #(.DEPTH(WBUF_DEPTH)) u_wbuf (
		.sys_clk(sys_clk),
		.rst(rst),
		.wb(wb.store)
	);

	assign idx = cpuAddr[OFFSET_W+IDX_W-1:OFFSET_W];
	assign tag = cpuAddr[ADDR_W-1:OFFSET_W+IDX_W];
	assign word = cpuAddr[OFFSET_W-1:2];
	assign sIdx = snoopAddr[OFFSET_W+IDX_W-1:OFFSET_W];
	assign sTag = snoopAddr[ADDR_W-1:OFFSET_W+IDX_W];
	assign hit = valid_q[idx] && (tagQ[idx] == tag);
	assign accept = (state_q == UOC_IDLE || state_q == UOC_DRAIN) && cpuReq && !cpuDone_q;
	assign rdHit = accept && !cpuWe && hit;
	assign wrStore = accept && cpuWe && hit && wbMode_q[idx];
	assign wrPush = accept && cpuWe && !wrStore && !wb.full;
	assign rdMiss = accept && (state_q == UOC_IDLE) && !cpuWe && !hit && wb.empty;
	assign drainGo = (state_q == UOC_IDLE) && !wb.empty && !rdHit && !wrStore && !wrPush;
	assign fillBeat = (state_q == UOC_FILL) && memReq_q && memAck;
	assign fillEnd = fillBeat && (beat_q == LAST_BEAT);
	assign snoopHit = snoopValid && valid_q[sIdx] && (tagQ[sIdx] == sTag);
	assign killNow = flush || (snoopValid && (sIdx == fillIdx_q) && (sTag == fillTag_q));
	assign wb.push = wrPush;
	assign wb.pushAddr = cpuAddr;
	assign wb.pushData = cpuWdata;
	assign wb.pop = (state_q == UOC_DRAIN) && memAck;
	assign cpuDone = cpuDone_q;
	assign cpuRdata = cpuRdata_q;
	assign memReq = memReq_q;
	assign memWe = memWe_q;
	assign memBurst = memBurst_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= UOC_IDLE;
			memReq_q <= 1'b0;
			memWe_q <= 1'b0;
			memBurst_q <= 1'b0;
			memAddr_q <= ADDR_RST;
			memWdata_q <= DATA_RST;
			beat_q <= FIRST_BEAT;
			fillIdx_q <= '0;
			fillTag_q <= '0;
			fillWb_q <= 1'b0;
		end else begin
			case (state_q)
				UOC_IDLE: begin
					if (drainGo) begin
						state_q <= UOC_DRAIN;
						memReq_q <= 1'b1;
						memWe_q <= 1'b1;
						memBurst_q <= 1'b0;
						memAddr_q <= wb.headAddr;
						memWdata_q <= wb.headData;
					end else if (rdMiss) begin
						fillIdx_q <= idx;
						fillTag_q <= tag;
						fillWb_q <= LARGE && cpuWbLine;
						beat_q <= FIRST_BEAT;
						memReq_q <= 1'b1;
						memBurst_q <= 1'b1;
						if (valid_q[idx] && dirty_q[idx]) begin
							state_q <= UOC_EVICT;
							memWe_q <= 1'b1;
							memAddr_q <= {tagQ[idx], idx, LINE_BASE};
							memWdata_q <= dataQ[{idx, FIRST_BEAT}];
						end else begin
							state_q <= UOC_FILL;
							memWe_q <= 1'b0;
							memAddr_q <= {tag, idx, LINE_BASE};
						end
					end
				end
				UOC_DRAIN: begin
					if (memAck) begin
						state_q <= UOC_IDLE;
						memReq_q <= 1'b0;
						memWe_q <= 1'b0;
					end
				end
				UOC_EVICT: begin
					if (memAck) begin
						if (beat_q == LAST_BEAT) begin
							state_q <= UOC_FILL;
							memReq_q <= 1'b0;
							memWe_q <= 1'b0;
							memAddr_q <= {fillTag_q, fillIdx_q, LINE_BASE};
							beat_q <= FIRST_BEAT;
						end else begin
							beat_q <= beat_q + 2'h1;
							memWdata_q <= dataQ[{fillIdx_q, beat_q + 2'h1}];
						end
					end
				end
				UOC_FILL: begin
					// Completion waits on memAck, which the system withholds until
					// any other master has written back its modified copy.
					if (fillBeat) begin
						if (beat_q == LAST_BEAT) begin
							state_q <= UOC_IDLE;
							memReq_q <= 1'b0;
							memBurst_q <= 1'b0;
						end else begin
							beat_q <= beat_q + 2'h1;
						end
					end else if (!memReq_q) begin
						memReq_q <= 1'b1;
					end
				end
				default: begin
					state_q <= UOC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (fillBeat) begin
			dataQ[{fillIdx_q, beat_q}] <= memRdata;
		end else if (accept && cpuWe && hit && (wrStore || wrPush)) begin
			dataQ[{idx, word}] <= cpuWdata;
		end
		if (fillEnd) begin
			tagQ[fillIdx_q] <= fillTag_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			valid_q <= '0;
			dirty_q <= '0;
			wbMode_q <= '0;
			kill_q <= 1'b0;
		end else begin
			if (rdMiss) begin
				valid_q[idx] <= 1'b0;
				kill_q <= 1'b0;
			end else if (state_q != UOC_IDLE && killNow) begin
				kill_q <= 1'b1;
			end
			if (fillEnd) begin
				valid_q[fillIdx_q] <= !kill_q && !killNow;
				dirty_q[fillIdx_q] <= 1'b0;
				wbMode_q[fillIdx_q] <= fillWb_q;
			end
			if (wrStore) begin
				dirty_q[idx] <= 1'b1;
			end
			if (snoopHit) begin
				valid_q[sIdx] <= 1'b0;
			end
			if (flush) begin
				valid_q <= '0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpuDone_q <= 1'b0;
			cpuRdata_q <= DATA_RST;
		end else begin
			cpuDone_q <= rdHit || wrStore || wrPush;
			if (rdHit) begin
				cpuRdata_q <= dataQ[{idx, word}];
			end
		end
	end

	chk_hit_no_bus: assert property (@(posedge sys_clk) disable iff (rst)
		rdHit && !memReq_q |=> cpuDone_q && !memReq_q)
		else $error("read hit started a bus cycle or gave no answer");
	chk_wt_push: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cpuWe && hit && !wbMode_q[idx] && !wb.full |-> wb.push)
		else $error("write-through hit was not posted to memory");
	chk_wb_hold: assert property (@(posedge sys_clk) disable iff (rst)
		wrStore |-> !wb.push ##1 dirty_q[$past(idx)])
		else $error("write-back hit went to the bus or left the line clean");
	chk_post_done: assert property (@(posedge sys_clk) disable iff (rst)
		wb.push |=> cpuDone_q && !wb.empty)
		else $error("posted write did not complete at once");
	chk_fill_four: assert property (@(posedge sys_clk) disable iff (rst)
		rdMiss && !dirty_q[idx] ##2 (memAck [*4]) |=> state_q == UOC_IDLE)
		else $error("line fill did not end after four beats");
	chk_miss_fill: assert property (@(posedge sys_clk) disable iff (rst)
		rdMiss && !(valid_q[idx] && dirty_q[idx]) |=> state_q == UOC_FILL && memReq_q)
		else $error("read miss did not start a line fill");
	chk_snoop_inval: assert property (@(posedge sys_clk) disable iff (rst)
		snoopHit |=> !valid_q[$past(sIdx)])
		else $error("snooped line stayed valid");
	chk_flush_all: assert property (@(posedge sys_clk) disable iff (rst)
		flush |=> valid_q == '0)
		else $error("flush left valid lines");
	chk_burst_align: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == UOC_FILL && memReq_q |-> memBurst_q && !memWe_q
			&& memAddr_q[OFFSET_W-1:0] == LINE_BASE)
		else $error("fill was not an aligned read burst");
	chk_valid_late: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == UOC_FILL |-> !valid_q[fillIdx_q])
		else $error("line marked valid before its fill ended");

	cov_read_hit: cover property (@(posedge sys_clk) disable iff (rst) rdHit);
	cov_fill_end: cover property (@(posedge sys_clk) disable iff (rst) fillEnd);
	cov_evict: cover property (@(posedge sys_clk) disable iff (rst) state_q == UOC_EVICT);
	cov_drain: cover property (@(posedge sys_clk) disable iff (rst) wb.pop);
endmodule

/* uoc_mem_model.sv */
// Behavioural model of external memory and of another bus master on the far side of the cache.
`timescale 1ns/100ps
module uoc_mem_model (
	input wire logic sys_clk,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic memBurst,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic memAck,
	output logic [31:0] memRdata,
	output logic snoopValid,
	output logic [31:0] snoopAddr
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] base;
	logic isWr;
	int beats;
	int lag = 0;
	int reads = 0;
	int writes = 0;
	logic [31:0] lastBase = 32'h0000_0000;

	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : ~a;
	endfunction

	// Another master writes its modified copy back before announcing it on the snoop lines.
	task automatic otherWrite(input logic [31:0] a, input logic [31:0] d);
		mem[a] = d;
		@(posedge sys_clk);
		#1 snoopValid = 1'b1;
		snoopAddr = a;
		@(posedge sys_clk);
		#1 snoopValid = 1'b0;
		snoopAddr = ~a;
	endtask

	initial begin
		memAck = 1'b0;
		memRdata = 32'h0000_0000;
		snoopValid = 1'b0;
		snoopAddr = 32'h0000_0000;
	end

	always begin
		@(posedge sys_clk);
		if (memReq === 1'b1) begin
			base = memAddr;
			isWr = memWe;
			beats = memBurst ? 4 : 1;
			if (!isWr) begin
				lastBase = base;
			end
			for (int b = 0; b < beats; b++) begin
				repeat (lag) @(posedge sys_clk);
				#1 memAck = 1'b1;
				memRdata = isWr ? ~memRdata : peek(base + 32'(4 * b));
				@(posedge sys_clk);
				if (isWr) begin
					mem[base + 32'(4 * b)] = memWdata;
					writes++;
				end else begin
					reads++;
				end
				#1 memAck = 1'b0;
				memRdata = ~memRdata;
			end
			@(posedge sys_clk);
		end
	end
endmodule

/* uoc_cache_tb_top.sv */
// Self-checking testbench of the unified on-chip cache.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module uoc_cache_tb_top;
	import uoc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cpuReq = 1'b0;
	logic cpuWe = 1'b0;
	logic cpuWbLine = 1'b0;
	logic [31:0] cpuAddr = 32'h0000_0000;
	logic [31:0] cpuWdata = 32'h0000_0000;
	logic flush = 1'b0;
	logic cpuDone, memReq, memWe, memBurst, memAck, snoopValid;
	logic [31:0] cpuRdata, memAddr, memWdata, memRdata, snoopAddr, rd;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int r0, w0, n;

	always #20 sys_clk = ~sys_clk;

	uoc_cache #(.LARGE(1'b1), .WBUF_DEPTH(WBUF_DEPTH)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.cpuReq(cpuReq), .cpuWe(cpuWe), .cpuWbLine(cpuWbLine), .cpuAddr(cpuAddr),
		.cpuWdata(cpuWdata), .cpuDone(cpuDone), .cpuRdata(cpuRdata), .memReq(memReq),
		.memWe(memWe), .memBurst(memBurst), .memAddr(memAddr), .memWdata(memWdata),
		.memAck(memAck), .memRdata(memRdata), .snoopValid(snoopValid), .snoopAddr(snoopAddr),
		.flush(flush));

	uoc_mem_model u_mem (.sys_clk(sys_clk), .memReq(memReq), .memWe(memWe),
		.memBurst(memBurst), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata), .snoopValid(snoopValid), .snoopAddr(snoopAddr));

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic wt(input int c);
		repeat (c) begin
			@(posedge sys_clk);
			#1;
		end
	endtask

	// One CPU word access; the request is held until cpuDone and then dropped for a cycle.
	task automatic acc(input logic we, input logic wbl, input logic [31:0] a, input logic [31:0] d);
		n = 0;
		cpuWe = we;
		cpuWbLine = wbl;
		cpuAddr = a;
		cpuWdata = d;
		cpuReq = 1'b1;
		do begin
			wt(1);
			n++;
		end while (cpuDone !== 1'b1 && n < 300);
		`CHK("cpuDone", 1'b1, cpuDone)
		rd = cpuRdata;
		cpuReq = 1'b0;
		wt(1);
	endtask

	task automatic waitWrites(input int target);
		for (int i = 0; i < 100 && u_mem.writes < target; i++) wt(1);
		`CHK("bus writes", target, u_mem.writes)
	endtask

	task automatic t_fill_hit();
		r0 = u_mem.reads;
		acc(1'b0, 1'b0, 32'h0000_1238, 32'h0000_0000);
		`CHK("miss data", 32'hFFFF_EDC7, rd)
		`CHK("fill beats", r0 + 4, u_mem.reads)
		`CHK("fill base", 32'h0000_1230, u_mem.lastBase)
		acc(1'b0, 1'b0, 32'h0000_1234, 32'h0000_0000);
		`CHK("hit data", 32'hFFFF_EDCB, rd)
		`CHK("hit beats", r0 + 4, u_mem.reads)
	endtask

	task automatic t_write_through();
		w0 = u_mem.writes;
		acc(1'b1, 1'b0, 32'h0000_1234, 32'h1111_2222);
		`CHK("posted write", w0, u_mem.writes)
		waitWrites(w0 + 1);
		`CHK("mem word", 32'h1111_2222, u_mem.peek(32'h0000_1234))
		acc(1'b0, 1'b0, 32'h0000_1234, 32'h0000_0000);
		`CHK("updated hit", 32'h1111_2222, rd)
	endtask

	task automatic t_snoop_flush();
		r0 = u_mem.reads;
		u_mem.otherWrite(32'h0000_1234, 32'h3333_4444);
		wt(1);
		acc(1'b0, 1'b0, 32'h0000_1234, 32'h0000_0000);
		`CHK("snooped data", 32'h3333_4444, rd)
		`CHK("refill beats", r0 + 4, u_mem.reads)
		flush = 1'b1;
		wt(1);
		flush = 1'b0;
		acc(1'b0, 1'b0, 32'h0000_1230, 32'h0000_0000);
		`CHK("flush refill", r0 + 8, u_mem.reads)
		`CHK("flush data", 32'hFFFF_EDCF, rd)
		acc(1'b0, 1'b0, 32'h0000_3230, 32'h0000_0000);
		acc(1'b0, 1'b0, 32'h0000_1230, 32'h0000_0000);
		`CHK("large lines", r0 + 12, u_mem.reads)
		`CHK("large data", 32'hFFFF_EDCF, rd)
	endtask

	task automatic t_write_back();
		acc(1'b0, 1'b1, 32'h0000_2000, 32'h0000_0000);
		w0 = u_mem.writes;
		acc(1'b1, 1'b0, 32'h0000_2004, 32'h5555_6666);
		wt(10);
		`CHK("held write", w0, u_mem.writes)
		acc(1'b0, 1'b0, 32'h0000_2004, 32'h0000_0000);
		`CHK("dirty hit", 32'h5555_6666, rd)
		acc(1'b0, 1'b0, 32'h0000_6000, 32'h0000_0000);
		`CHK("evict beats", w0 + 4, u_mem.writes)
		`CHK("evicted word", 32'h5555_6666, u_mem.peek(32'h0000_2004))
		acc(1'b1, 1'b0, 32'h0000_6008, 32'h7777_8888);
		waitWrites(w0 + 5);
	endtask

	task automatic t_buffer_full();
		u_mem.lag = 30;
		w0 = u_mem.writes;
		for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, 32'h0000_9000 + 32'(4 * i), 32'(i));
		`CHK("four posted", w0, u_mem.writes)
		acc(1'b1, 1'b0, 32'h0000_9010, 32'h0000_0004);
		`CHK("fifth waited", 1'b1, n > 10)
		u_mem.lag = 0;
		waitWrites(w0 + 5);
		`CHK("last drained", 32'h0000_0004, u_mem.peek(32'h0000_9010))
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		#1 rst = 1'b0;
		t_fill_hit();
		t_write_through();
		t_snoop_flush();
		t_write_back();
		t_buffer_full();
		print_verdict();
	end
endmodule
